// *** fis_pkg.sv ***
// Purpose: Shared constants and types of the flash integrity scanner.
// Assumes: Byte-wide register port, word-addressed flash read port.
// Notes: Register offsets are byte indices on the plain register port.
package fis_pkg;
   localparam int REG_AW = 2;
   localparam int DATA_W = 8;
   localparam int WORD_W = 16;

   localparam logic [REG_AW-1:0] OFF_CTRL_PRIMARY = 2'h0;
   localparam logic [REG_AW-1:0] OFF_CTRL_MODE_SECTION = 2'h1;
   localparam logic [REG_AW-1:0] OFF_STATUS = 2'h2;

   localparam logic [DATA_W-1:0] RST_CTRL_PRIMARY = 8'h00;
   localparam logic [DATA_W-1:0] RST_CTRL_MODE_SECTION = 8'h00;
   localparam logic [DATA_W-1:0] RST_STATUS = 8'h02;
   localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

   // Primary control fields
   localparam int BIT_ENABLE = 0;
   localparam int BIT_ARM = 1;
   localparam int BIT_SELF_RESET = 7;
   // Mode and section fields
   localparam int MODE_LSB = 4;
   localparam int SRC_LSB = 0;
   // Status fields
   localparam int BIT_BUSY = 0;
   localparam int BIT_PASS = 1;

   localparam logic [1:0] MODE_PRIORITY = 2'h0;
   localparam logic [1:0] MODE_RESERVED = 2'h1;
   localparam logic [1:0] MODE_BACKGROUND = 2'h2;
   localparam logic [1:0] MODE_CONTINUOUS = 2'h3;

   localparam logic [1:0] SRC_FLASH = 2'h0;
   localparam logic [1:0] SRC_BOOT_AND_CODE = 2'h1;
   localparam logic [1:0] SRC_BOOT = 2'h2;
   localparam logic [1:0] SRC_RESERVED = 2'h3;

   // Cycle counts on the peripheral clock
   localparam int START_DELAY_CYC = 3;
   localparam int FETCH_PERIOD_CYC = 3;
   localparam logic [1:0] START_LAST = 2'(START_DELAY_CYC - 1);
   localparam logic [1:0] PACE_LAST = 2'(FETCH_PERIOD_CYC - 2);

   localparam logic [WORD_W-1:0] CRC_SEED = 16'hffff;
   localparam logic [WORD_W-1:0] CRC_GOOD = 16'h0000;

   typedef enum {ST_IDLE, ST_DELAY, ST_REQ, ST_PACE} fis_state_t;

   typedef struct packed {
      logic [1:0] mode;
      logic [1:0] src;
   } fis_cfg_t;

   typedef struct packed {
      logic arm;
      logic enable;
   } fis_ctrl_t;
endpackage

// *** flash_integrity_scanner.sv ***
// Purpose: Flash integrity scanner control, status and CRC fetch engine.
// Assumes: CPU_SLEEP, boot scan straps and flash port are on SYS_CLK.
// Notes: CRC residue over a section including its stored checksum must be zero.
// Function
// - Sleep freezes the scan, resumes on wake
// - Pending priority check runs first after wake
// - After NMI, primary control writes ignored
// - Self-reset strobe clears registers except arm one cycle later
// - Arm low: self-reset accepted even when busy
// - Arm high: self-reset accepted only when idle
// - Arm bit raises NMI, cleared by system reset
// - Arm bit set only while not busy
// - Enable write of one starts new check
// - Clearing enable stops at section end
// - Startup scan leaves enable reading one
// - Mode/section writes blocked when busy or NMI
// - Mode: priority, background single, continuous
// - Continuous restarts after pass, stops on fail
// - Startup scan leaves mode reading background
// - Section: whole, boot plus code, boot
// - Startup scan shows the checked section
// - Status read-only, resets to 0x02
// - Pass flag: one at reset, zero while busy
// - Busy flag is one during a check
// - Mismatch clears pass, armed raises sticky NMI
// - Priority/startup fetch one word every third cycle
// - Check begins three cycles after enable
`timescale 1ns/100ps
module fis_flash_integrity_scanner #(
   parameter int FLASH_AW = 12,
   parameter logic [15:0] CRC_POLY = 16'h1021
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic [fis_pkg::REG_AW-1:0] REG_ADDR,
   input wire logic [fis_pkg::DATA_W-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [fis_pkg::DATA_W-1:0] REG_RDATA,
   input wire logic CPU_SLEEP,
   input wire logic BOOT_SCAN_EN,
   input wire logic [1:0] BOOT_SCAN_SRC,
   input wire logic [FLASH_AW-1:0] BOOT_LAST_WORD,
   input wire logic [FLASH_AW-1:0] CODE_LAST_WORD,
   input wire logic [FLASH_AW-1:0] FLASH_LAST_WORD,
   output logic FLASH_REQ,
   output logic FLASH_PRIO,
   output logic [FLASH_AW-1:0] FLASH_ADDR,
   input wire logic FLASH_GNT,
   input wire logic [fis_pkg::WORD_W-1:0] FLASH_RDATA,
   output logic CPU_STALL,
   output logic NMI_REQ
);
   fis_pkg::fis_state_t state_q, state_d;
   fis_pkg::fis_ctrl_t ctrl_q, ctrl_d;
   fis_pkg::fis_cfg_t cfg_q, cfg_d;
   logic pass_q, pass_d;
   logic nmi_q, nmi_d;
   logic srst_q;
   logic init_q;
   logic boot_q, boot_d;
   logic wake_q, wake_d;
   logic [1:0] cnt_q, cnt_d;
   logic [FLASH_AW-1:0] addr_q, addr_d;
   logic [fis_pkg::WORD_W-1:0] crc_q, crc_d;
   logic req_q, req_d;
   logic prio_q, prio_d;
   logic stall_q, stall_d;
   logic [fis_pkg::DATA_W-1:0] rdata_q, rdata_d;

   // Serial CRC, one bit per step, most significant bit first
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [15:0] din);
      logic [15:0] c;
      c = crc;
      for (int i = 15; i >= 0; i--) begin
         if (c[15] ^ din[i]) begin
            c = {c[14:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[14:0], 1'b0};
         end
      end
      return c;
   endfunction

   // Register decode
   wire busy = (state_q != fis_pkg::ST_IDLE);
   wire sel_a = (REG_ADDR == fis_pkg::OFF_CTRL_PRIMARY);
   wire sel_b = (REG_ADDR == fis_pkg::OFF_CTRL_MODE_SECTION);
   wire sel_s = (REG_ADDR == fis_pkg::OFF_STATUS);
   wire wr_a = REG_WR && sel_a && !nmi_q;
   wire wr_b = REG_WR && sel_b && !nmi_q && !busy;
   wire srst_ok = wr_a && REG_WDATA[fis_pkg::BIT_SELF_RESET] && (!ctrl_q.arm || !busy);
   wire [1:0] wr_mode = REG_WDATA[fis_pkg::MODE_LSB +: 2];
   wire [1:0] wr_src = REG_WDATA[fis_pkg::SRC_LSB +: 2];
   wire sw_start = wr_a && REG_WDATA[fis_pkg::BIT_ENABLE];
   wire boot_start = !init_q && BOOT_SCAN_EN;

   // Status shows pass only once idle, so a running check reads zero
   wire pass_vis = pass_q && !busy;
   wire [fis_pkg::DATA_W-1:0] rd_a = {6'h00, ctrl_q.arm, ctrl_q.enable};
   wire [fis_pkg::DATA_W-1:0] rd_b = {2'h0, cfg_q.mode, 2'h0, cfg_q.src};
   wire [fis_pkg::DATA_W-1:0] rd_s = {6'h00, pass_vis, busy};
   wire [fis_pkg::DATA_W-1:0] rd_mux = sel_a ? rd_a :
                                       sel_b ? rd_b :
                                       sel_s ? rd_s : fis_pkg::READ_ZERO;

   // Section end select
   wire [FLASH_AW-1:0] last_word =
      (cfg_q.src == fis_pkg::SRC_BOOT) ? BOOT_LAST_WORD :
      (cfg_q.src == fis_pkg::SRC_BOOT_AND_CODE) ? CODE_LAST_WORD : FLASH_LAST_WORD;

   // Flash stores the low byte at the lower address; the checksum's high byte
   // sits first, so bytes are fed in address order
   wire [15:0] word_in = {FLASH_RDATA[7:0], FLASH_RDATA[15:8]};
   wire [15:0] crc_next = crc_step(crc_q, word_in);
   wire took = (state_q == fis_pkg::ST_REQ) && req_q && FLASH_GNT && !CPU_SLEEP;
   wire at_end = (addr_q == last_word);
   wire crc_ok = (crc_next == fis_pkg::CRC_GOOD);
   wire paced = boot_q || (cfg_q.mode == fis_pkg::MODE_PRIORITY);

   always_comb begin
      state_d = state_q;
      ctrl_d = ctrl_q;
      cfg_d = cfg_q;
      pass_d = pass_q;
      nmi_d = nmi_q;
      boot_d = boot_q;
      wake_d = wake_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      crc_d = crc_q;
      // Engine, frozen while the CPU sleeps
      if (!CPU_SLEEP) begin
         unique case (state_q)
            fis_pkg::ST_IDLE: begin
            end
            fis_pkg::ST_DELAY: begin
               if (cnt_q == fis_pkg::START_LAST) begin
                  state_d = fis_pkg::ST_REQ;
               end else begin
                  cnt_d = cnt_q + 2'h1;
               end
            end
            fis_pkg::ST_REQ: begin
               if (took) begin
                  crc_d = crc_next;
                  if (at_end) begin
                     pass_d = crc_ok;
                     if (!crc_ok) begin
                        nmi_d = nmi_q | ctrl_q.arm;
                        state_d = fis_pkg::ST_IDLE;
                        boot_d = 1'b0;
                     end else if (cfg_q.mode == fis_pkg::MODE_CONTINUOUS && ctrl_q.enable && !boot_q) begin
                        addr_d = '0;
                        crc_d = fis_pkg::CRC_SEED;
                     end else begin
                        state_d = fis_pkg::ST_IDLE;
                        boot_d = 1'b0;
                     end
                  end else begin
                     addr_d = addr_q + FLASH_AW'(1);
                     if (paced) begin
                        state_d = fis_pkg::ST_PACE;
                        cnt_d = 2'h0;
                     end
                  end
               end
            end
            fis_pkg::ST_PACE: begin
               if (cnt_q == fis_pkg::PACE_LAST) begin
                  state_d = fis_pkg::ST_REQ;
               end else begin
                  cnt_d = cnt_q + 2'h1;
               end
            end
         endcase
      end
      // A priority check still waiting when sleep came stalls the CPU on wake
      if (CPU_SLEEP && state_q == fis_pkg::ST_DELAY && paced) begin
         wake_d = 1'b1;
      end
      if (state_d != fis_pkg::ST_DELAY) begin
         wake_d = 1'b0;
      end
      // Software access
      if (wr_a) begin
         ctrl_d.enable = REG_WDATA[fis_pkg::BIT_ENABLE];
         if (REG_WDATA[fis_pkg::BIT_ARM] && !busy) begin
            ctrl_d.arm = 1'b1;
         end
      end
      if (wr_b) begin
         if (wr_mode != fis_pkg::MODE_RESERVED) begin
            cfg_d.mode = wr_mode;
         end
         if (wr_src != fis_pkg::SRC_RESERVED) begin
            cfg_d.src = wr_src;
         end
      end
      // Startup scan, taken once at the first edge after reset release
      if (boot_start) begin
         ctrl_d.enable = 1'b1;
         cfg_d.mode = fis_pkg::MODE_BACKGROUND;
         if (BOOT_SCAN_SRC != fis_pkg::SRC_RESERVED) begin
            cfg_d.src = BOOT_SCAN_SRC;
         end
         boot_d = 1'b1;
      end
      if (sw_start || boot_start) begin
         state_d = fis_pkg::ST_DELAY;
         cnt_d = 2'h0;
         addr_d = '0;
         crc_d = fis_pkg::CRC_SEED;
         pass_d = 1'b0;
         wake_d = 1'b0;
      end
      // Self-reset acts one cycle after the strobe write; the arm bit survives
      if (srst_q) begin
         ctrl_d.enable = 1'b0;
         cfg_d = '0;
         pass_d = 1'b0;
         state_d = fis_pkg::ST_IDLE;
         boot_d = 1'b0;
         wake_d = 1'b0;
      end
   end

   assign prio_d = boot_d || (cfg_d.mode == fis_pkg::MODE_PRIORITY);
   assign req_d = (state_d == fis_pkg::ST_REQ) && !CPU_SLEEP;
   // No stall during the start delay unless a sleep interrupted it
   assign stall_d = prio_d && ((state_d == fis_pkg::ST_REQ) || (state_d == fis_pkg::ST_PACE) || wake_d);
   assign rdata_d = REG_RD ? rd_mux : fis_pkg::READ_ZERO;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         state_q <= fis_pkg::ST_IDLE;
         ctrl_q <= '0;
         cfg_q <= '0;
         pass_q <= fis_pkg::RST_STATUS[fis_pkg::BIT_PASS];
         nmi_q <= 1'b0;
         srst_q <= 1'b0;
         init_q <= 1'b0;
         boot_q <= 1'b0;
         wake_q <= 1'b0;
         cnt_q <= 2'h0;
         addr_q <= '0;
         crc_q <= fis_pkg::CRC_SEED;
         req_q <= 1'b0;
         prio_q <= 1'b0;
         stall_q <= 1'b0;
         rdata_q <= fis_pkg::READ_ZERO;
      end else begin
         state_q <= state_d;
         ctrl_q <= ctrl_d;
         cfg_q <= cfg_d;
         pass_q <= pass_d;
         nmi_q <= nmi_d;
         srst_q <= srst_ok;
         init_q <= 1'b1;
         boot_q <= boot_d;
         wake_q <= wake_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         crc_q <= crc_d;
         req_q <= req_d;
         prio_q <= prio_d;
         stall_q <= stall_d;
         rdata_q <= rdata_d;
      end
   end

   assign REG_RDATA = rdata_q;
   assign FLASH_REQ = req_q;
   assign FLASH_PRIO = prio_q;
   assign FLASH_ADDR = addr_q;
   assign CPU_STALL = stall_q;
   assign NMI_REQ = nmi_q;
endmodule

// *** fis_flash_model.sv ***
// Purpose: Flash read port model shared with the CPU, answering scan fetches.
// Assumes: Section data is a fixed pattern with its checksum in the last word.
// Notes: Slow mode grants every other cycle to mimic the CPU holding the port.
`timescale 1ns/100ps
module fis_flash_model #(
   parameter logic [15:0] POLY = 16'h1021
) (
   input wire logic clk,
   input wire logic req,
   input wire logic [11:0] addr,
   input wire logic [11:0] last,
   input wire logic slow,
   input wire logic bad,
   output logic gnt,
   output logic [15:0] rdata
);
   logic tog = 1'b0;
   logic [15:0] sum;
   function automatic logic [15:0] word(input int a);
      return 16'ha5c3 + 16'(a);
   endfunction
   function automatic logic [15:0] crc_to(input int n);
      logic [15:0] c;
      logic [15:0] r;
      logic [15:0] w;
      c = 16'hffff;
      for (int a = 0; a < n; a++) begin
         // Low address byte enters the CRC first
         w = word(a);
         r = {w[7:0], w[15:8]};
         for (int i = 15; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ r[i]) ? POLY : 16'h0000);
         end
      end
      return c;
   endfunction
   assign sum = crc_to(int'(last));
   assign gnt = req && (!slow || tog);
   // Outside a grant the data lines show a moving pattern, never the last word
   assign rdata = !gnt ? ~word(int'(addr)) :
      (addr == last) ? {sum[7:0], sum[15:8]} ^ {15'h0000, bad} : word(int'(addr));
   always @(posedge clk) tog <= ~tog;
endmodule

// *** fis_scanner_assertions.sv ***
// Purpose: Port-level checks of the flash integrity scanner.
// Assumes: Single clock domain, synchronous active-low reset.
// Notes: Bound to the scanner top module.
`timescale 1ns/100ps
module fis_scanner_checker (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic [1:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_RDATA,
   input wire logic CPU_SLEEP,
   input wire logic FLASH_REQ,
   input wire logic FLASH_PRIO,
   input wire logic FLASH_GNT,
   input wire logic CPU_STALL,
   input wire logic NMI_REQ
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   chk_sleep_no_fetch: assert property (CPU_SLEEP && $past(CPU_SLEEP) |-> !FLASH_REQ)
      else $error("flash request while asleep");
   chk_nmi_sticky: assert property (NMI_REQ |=> NMI_REQ)
      else $error("interrupt request dropped");
   chk_prio_pace: assert property (FLASH_REQ && FLASH_GNT && FLASH_PRIO && !CPU_SLEEP |=> !FLASH_REQ [*2])
      else $error("priority fetch too early");
   chk_start_gap: assert property (REG_WR && REG_ADDR == 2'h0 && REG_WDATA[0] && !REG_WDATA[7] && !NMI_REQ
      |=> !FLASH_REQ [*3])
      else $error("fetch inside start delay");
   chk_bg_no_stall: assert property (FLASH_REQ && !FLASH_PRIO |-> !CPU_STALL)
      else $error("background fetch stalls cpu");
   chk_status_spare: assert property (REG_RD && REG_ADDR == 2'h2 |=> REG_RDATA[7:2] == 6'h00)
      else $error("status spare bits set");
   chk_pass_busy: assert property (REG_RD && REG_ADDR == 2'h2 |=> !(REG_RDATA[1] && REG_RDATA[0]))
      else $error("pass shown while busy");
   chk_busy_fetch: assert property (REG_RD && REG_ADDR == 2'h2 && FLASH_REQ |=> REG_RDATA[0])
      else $error("fetching but not busy");
endmodule
bind fis_flash_integrity_scanner fis_scanner_checker i_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .CPU_SLEEP(CPU_SLEEP), .FLASH_REQ(FLASH_REQ), .FLASH_PRIO(FLASH_PRIO), .FLASH_GNT(FLASH_GNT),
   .CPU_STALL(CPU_STALL), .NMI_REQ(NMI_REQ));

// *** fis_flash_integrity_scanner_test.sv ***
// Purpose: Self-checking bench of the flash integrity scanner.
// Assumes: Sections end at words 1, 3 and 5 to keep scans short.
// Notes: Status polling is bounded; a hang counts as a mismatch.
`timescale 1ns/100ps
module fis_flash_integrity_scanner_test;
   logic SYS_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic [1:0] REG_ADDR = 2'h0;
   logic [7:0] REG_WDATA = 8'h00;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic CPU_SLEEP = 1'b0;
   logic BOOT_SCAN_EN = 1'b0;
   logic [1:0] BOOT_SCAN_SRC = 2'h0;
   logic [11:0] last_w = 12'h001;
   logic slow = 1'b0;
   logic bad = 1'b0;
   logic saw_stall = 1'b0;
   logic [7:0] REG_RDATA;
   logic [11:0] FLASH_ADDR;
   logic [15:0] FLASH_RDATA;
   logic FLASH_REQ, FLASH_PRIO, FLASH_GNT, CPU_STALL, NMI_REQ;
   int err_total = 0;
   int total_checks = 0;
   initial forever #5 SYS_CLK = ~SYS_CLK;
   always @(posedge SYS_CLK) if (CPU_STALL === 1'b1) saw_stall <= 1'b1;
   fis_flash_integrity_scanner i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CPU_SLEEP(CPU_SLEEP),
      .BOOT_SCAN_EN(BOOT_SCAN_EN), .BOOT_SCAN_SRC(BOOT_SCAN_SRC), .BOOT_LAST_WORD(12'h001),
      .CODE_LAST_WORD(12'h003), .FLASH_LAST_WORD(12'h005), .FLASH_REQ(FLASH_REQ), .FLASH_PRIO(FLASH_PRIO),
      .FLASH_ADDR(FLASH_ADDR), .FLASH_GNT(FLASH_GNT), .FLASH_RDATA(FLASH_RDATA), .CPU_STALL(CPU_STALL),
      .NMI_REQ(NMI_REQ));
   fis_flash_model i_flash (.clk(SYS_CLK), .req(FLASH_REQ), .addr(FLASH_ADDR), .last(last_w), .slow(slow),
      .bad(bad), .gnt(FLASH_GNT), .rdata(FLASH_RDATA));
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1 d = REG_RDATA;
   endtask
   task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      cmp(d, exp);
   endtask
   // Polls busy; CPU sleep freezes the scan, so callers wake it first
   task automatic wait_idle;
      logic [7:0] d;
      int n;
      n = 0;
      do begin
         rd(2'h2, d);
         n++;
      end while (d[0] !== 1'b0 && n < 500);
      if (n >= 500) begin
         err_total++;
         final_report();
      end
   endtask
   task automatic t_regs;
      rchk(2'h0, 8'h00);
      rchk(2'h1, 8'h00);
      rchk(2'h2, 8'h02);
      wr(2'h2, 8'hff);
      rchk(2'h2, 8'h02);
      $display("test regs done");
   endtask
   task automatic t_prio;
      wr(2'h1, 8'h02);
      rchk(2'h1, 8'h02);
      wr(2'h1, 8'h13);
      rchk(2'h1, 8'h02);
      wr(2'h0, 8'h01);
      rchk(2'h2, 8'h01);
      wait_idle();
      rchk(2'h2, 8'h02);
      rchk(2'h0, 8'h01);
      cmp({7'h00, saw_stall}, 8'h01);
      wr(2'h0, 8'h01);
      rchk(2'h2, 8'h01);
      wait_idle();
      $display("test prio done");
   endtask
   task automatic t_sleep;
      last_w = 12'h003;
      slow = 1'b1;
      wr(2'h1, 8'h21);
      wr(2'h0, 8'h01);
      CPU_SLEEP <= 1'b1;
      repeat (20) @(posedge SYS_CLK);
      rchk(2'h2, 8'h01);
      wr(2'h1, 8'h30);
      wr(2'h0, 8'h03);
      CPU_SLEEP <= 1'b0;
      wait_idle();
      rchk(2'h1, 8'h21);
      rchk(2'h0, 8'h01);
      rchk(2'h2, 8'h02);
      $display("test sleep done");
   endtask
   task automatic t_cont;
      last_w = 12'h005;
      slow = 1'b0;
      wr(2'h1, 8'h30);
      wr(2'h0, 8'h01);
      repeat (80) @(posedge SYS_CLK);
      rchk(2'h2, 8'h01);
      wr(2'h0, 8'h00);
      wait_idle();
      rchk(2'h2, 8'h02);
      wr(2'h0, 8'h01);
      wr(2'h0, 8'h80);
      rchk(2'h0, 8'h00);
      rchk(2'h1, 8'h00);
      rchk(2'h2, 8'h00);
      $display("test continuous done");
   endtask
   task automatic t_nmi;
      last_w = 12'h005;
      slow = 1'b1;
      wr(2'h0, 8'h02);
      wr(2'h0, 8'h80);
      rchk(2'h0, 8'h02);
      bad = 1'b1;
      wr(2'h0, 8'h03);
      wr(2'h0, 8'h83);
      rchk(2'h2, 8'h01);
      wait_idle();
      cmp({7'h00, NMI_REQ}, 8'h01);
      rchk(2'h2, 8'h00);
      wr(2'h0, 8'h00);
      rchk(2'h0, 8'h03);
      wr(2'h1, 8'h30);
      rchk(2'h1, 8'h00);
      $display("test nmi done");
   endtask
   task automatic t_boot;
      @(posedge SYS_CLK);
      RST_N <= 1'b0;
      BOOT_SCAN_EN <= 1'b1;
      BOOT_SCAN_SRC <= 2'h1;
      bad = 1'b0;
      last_w = 12'h003;
      repeat (12) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      rchk(2'h0, 8'h01);
      rchk(2'h1, 8'h21);
      cmp({7'h00, NMI_REQ}, 8'h00);
      wait_idle();
      rchk(2'h2, 8'h02);
      $display("test boot done");
   endtask
   initial begin
      repeat (12) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      t_regs();
      t_prio();
      t_sleep();
      t_cont();
      t_nmi();
      t_boot();
      final_report();
   end
endmodule
